// >>> core/ashc_top.sv
// accessory switch host control: power gating, reset and i2c target with its registers
// assumes supply-valid comparators, id and attach levels arrive asynchronously on pins,
// and link_clk samples scl/sda far faster than the 400 khz serial clock
`timescale 1ns/1ps
module ashc_top #(
    parameter logic [6:0] TARGET_ADDRESS = ashc_pkg::TARGET_ADDR
) (
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic link_clk,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_n,
    input  wire logic bat_supply_valid,
    input  wire logic bus_supply_input,
    input  wire logic io_supply,
    input  wire logic connector_id_pin,
    input  wire logic attach_state,
    output logic      int_n,
    output logic      switch_paths_open,
    output logic      detect_enable,
    output logic      charge_enable,
    output logic      ldo_enable,
    output logic      host_enable,
    output logic      illegal_supply,
    output logic      standby
);
    // reserved i2c address groups cannot be served
    if (TARGET_ADDRESS[6:3] == ashc_pkg::RSV_ADDR_LO
        || TARGET_ADDRESS[6:3] == ashc_pkg::RSV_ADDR_HI) begin : g_bad_addr
        $error("target address lies in a reserved group");
    end

    ashc_pkg::ashc_core_t    c_ff;
    ashc_pkg::ashc_core_t    nxt_c;
    ashc_pkg::ashc_link_st_t l_ff;
    ashc_pkg::ashc_link_st_t nxt_l;

    // second stage differs from third: one event per toggle
    function automatic logic went(input logic older, input logic newer);
        return older ^ newer;
    endfunction

    // ---------------- core domain ----------------
    logic       req_ev;
    logic [7:0] sts_val;
    assign req_ev = went(c_ff.req_s[2], c_ff.req_s[1]);

    always_comb begin
        sts_val = '0;
        sts_val[ashc_pkg::STS_BAT]     = c_ff.bat_s[1];
        sts_val[ashc_pkg::STS_BUS]     = c_ff.bus_s[1];
        sts_val[ashc_pkg::STS_IO]      = c_ff.io_s[1];
        sts_val[ashc_pkg::STS_ID]      = c_ff.id_s[1];
        sts_val[ashc_pkg::STS_ATTACH]  = c_ff.att_s[1];
        sts_val[ashc_pkg::STS_STANDBY] = c_ff.standby;
    end

    always_comb begin
        nxt_c = c_ff;
        nxt_c.bat_s = {c_ff.bat_s[1:0], bat_supply_valid};
        nxt_c.bus_s = {c_ff.bus_s[1:0], bus_supply_input};
        nxt_c.io_s  = {c_ff.io_s[1:0], io_supply};
        nxt_c.id_s  = {c_ff.id_s[1:0], connector_id_pin};
        nxt_c.att_s = {c_ff.att_s[1:0], attach_state};
        nxt_c.req_s = {c_ff.req_s[1:0], l_ff.req_tgl};
        // any supply order works: only the current valid levels steer the state
        case (c_ff.pwr)
            ashc_pkg::PW_OFF: begin
                if (c_ff.bat_s[1] || c_ff.bus_s[1]) nxt_c.pwr = ashc_pkg::PW_INIT;
            end
            ashc_pkg::PW_INIT: begin
                nxt_c.pwr = (c_ff.bat_s[1] || c_ff.bus_s[1]) ? ashc_pkg::PW_STANDBY
                                                             : ashc_pkg::PW_OFF;
            end
            ashc_pkg::PW_STANDBY: begin
                if (!c_ff.bat_s[1] && !c_ff.bus_s[1]) nxt_c.pwr = ashc_pkg::PW_OFF;
            end
            default: nxt_c.pwr = ashc_pkg::PW_OFF;
        endcase
        if (req_ev) begin
            nxt_c.ack_tgl = ~c_ff.ack_tgl;
            if (l_ff.req_we) begin
                if (l_ff.req_addr == ashc_pkg::REG_RESET_CTRL
                    && l_ff.req_data[ashc_pkg::RST_BIT]) nxt_c.pwr = ashc_pkg::PW_INIT;
                if (l_ff.req_addr == ashc_pkg::REG_CONTROL) nxt_c.control = l_ff.req_data;
            end else begin
                case (l_ff.req_addr)
                    ashc_pkg::REG_STATUS:  nxt_c.rdata = sts_val;
                    ashc_pkg::REG_EVENTS:  nxt_c.rdata = c_ff.events;
                    ashc_pkg::REG_CONTROL: nxt_c.rdata = c_ff.control;
                    default:               nxt_c.rdata = ashc_pkg::BYTE_RESET;
                endcase
                // reading the event register clears it
                if (l_ff.req_addr == ashc_pkg::REG_EVENTS) nxt_c.events = ashc_pkg::BYTE_RESET;
            end
        end
        // set after clear: a change in the clearing cycle is kept
        if (c_ff.pwr == ashc_pkg::PW_STANDBY && c_ff.bat_s[1]) begin
            if (went(c_ff.id_s[2], c_ff.id_s[1]))
                nxt_c.events[ashc_pkg::EVT_ID] = 1'b1;
            if (went(c_ff.att_s[2], c_ff.att_s[1]))
                nxt_c.events[ashc_pkg::EVT_ATTACH] = 1'b1;
        end
        if (c_ff.pwr == ashc_pkg::PW_INIT) begin
            nxt_c.control  = ashc_pkg::BYTE_RESET;
            nxt_c.events   = ashc_pkg::BYTE_RESET;
            nxt_c.rdata    = ashc_pkg::BYTE_RESET;
            nxt_c.init_tgl = ~c_ff.init_tgl;
        end
        nxt_c.standby    = nxt_c.pwr == ashc_pkg::PW_STANDBY;
        nxt_c.paths_open = !nxt_c.standby;
        nxt_c.det_en     = c_ff.bat_s[1] && nxt_c.standby;
        nxt_c.ldo_en     = c_ff.bat_s[1] && nxt_c.standby;
        nxt_c.chg_en     = c_ff.bus_s[1];
        nxt_c.host_en    = c_ff.io_s[1] && c_ff.bat_s[1];
        nxt_c.illegal    = c_ff.io_s[1] && !c_ff.bat_s[1] && !c_ff.bus_s[1];
        nxt_c.int_n      = !((|nxt_c.events) && !nxt_c.control[ashc_pkg::CTL_INT_MASK]
                             && nxt_c.host_en);
        if (!rstn) begin
            nxt_c            = '0;
            // link may still hold an old toggle: track it, no stale request after release
            nxt_c.req_s      = {c_ff.req_s[1:0], l_ff.req_tgl};
            nxt_c.pwr        = ashc_pkg::PW_OFF;
            nxt_c.int_n      = 1'b1;
            nxt_c.paths_open = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        c_ff <= nxt_c;
    end

    assign int_n             = c_ff.int_n;
    assign switch_paths_open = c_ff.paths_open;
    assign detect_enable     = c_ff.det_en;
    assign charge_enable     = c_ff.chg_en;
    assign ldo_enable        = c_ff.ldo_en;
    assign host_enable       = c_ff.host_en;
    assign illegal_supply    = c_ff.illegal;
    assign standby           = c_ff.standby;

    // ---------------- link domain ----------------
    // sampling clock must be many times the 400 khz scl so every bit is seen
    logic lk_scl;
    logic lk_sda;
    logic lk_rise;
    logic lk_fall;
    logic lk_start;
    logic lk_stop;
    logic lk_host;
    logic lk_init;
    assign lk_scl   = l_ff.scl_s[1];
    assign lk_sda   = l_ff.sda_s[1];
    assign lk_rise  = lk_scl && !l_ff.scl_s[2];
    assign lk_fall  = !lk_scl && l_ff.scl_s[2];
    assign lk_start = lk_scl && l_ff.scl_s[2] && !lk_sda && l_ff.sda_s[2];
    assign lk_stop  = lk_scl && l_ff.scl_s[2] && lk_sda && !l_ff.sda_s[2];
    assign lk_host  = l_ff.host_s[1];
    assign lk_init  = went(l_ff.init_s[2], l_ff.init_s[1]);

    always_comb begin
        nxt_l = l_ff;
        nxt_l.scl_s  = {l_ff.scl_s[1:0], scl_i};
        nxt_l.sda_s  = {l_ff.sda_s[1:0], sda_i};
        nxt_l.rst_s  = {l_ff.rst_s[0], rstn};
        nxt_l.host_s = {l_ff.host_s[0], c_ff.host_en};
        nxt_l.ack_s  = {l_ff.ack_s[1:0], c_ff.ack_tgl};
        nxt_l.init_s = {l_ff.init_s[1:0], c_ff.init_tgl};
        // core data is stable once its toggle is seen here
        if (went(l_ff.ack_s[2], l_ff.ack_s[1])) nxt_l.rdata = c_ff.rdata;
        if (lk_init) nxt_l.ptr = ashc_pkg::PTR_RESET;
        if (!lk_host) begin
            nxt_l.st       = ashc_pkg::LK_IDLE;
            nxt_l.sda_oe_n = 1'b1;
        end else if (lk_start) begin
            nxt_l.st       = ashc_pkg::LK_ADDR;
            nxt_l.bits     = ashc_pkg::BITS_NONE;
            nxt_l.sda_oe_n = 1'b1;
        end else if (lk_stop) begin
            nxt_l.st       = ashc_pkg::LK_IDLE;
            nxt_l.sda_oe_n = 1'b1;
        end else begin
            case (l_ff.st)
                ashc_pkg::LK_IDLE: begin
                    nxt_l.sda_oe_n = 1'b1;
                end
                ashc_pkg::LK_ADDR, ashc_pkg::LK_WDATA: begin
                    if (lk_rise) begin
                        nxt_l.shreg = {l_ff.shreg[6:0], lk_sda};
                        nxt_l.bits  = l_ff.bits + ashc_pkg::BIT_STEP;
                    end else if (lk_fall && l_ff.bits == ashc_pkg::BYTE_BITS) begin
                        nxt_l.bits = ashc_pkg::BITS_NONE;
                        if (l_ff.st == ashc_pkg::LK_ADDR) begin
                            if (l_ff.shreg[7:1] == TARGET_ADDRESS) begin
                                nxt_l.sda_oe_n = 1'b0;
                                nxt_l.rw       = l_ff.shreg[0];
                                nxt_l.want_ptr = 1'b1;
                                nxt_l.st       = ashc_pkg::LK_ADDR_ACK;
                                if (l_ff.shreg[0]) begin
                                    nxt_l.req_tgl  = ~l_ff.req_tgl;
                                    nxt_l.req_we   = 1'b0;
                                    nxt_l.req_addr = l_ff.ptr;
                                end
                            end else begin
                                nxt_l.st = ashc_pkg::LK_IDLE;
                            end
                        end else begin
                            nxt_l.sda_oe_n = 1'b0;
                            nxt_l.st       = ashc_pkg::LK_WACK;
                            if (l_ff.want_ptr) begin
                                nxt_l.ptr      = l_ff.shreg;
                                nxt_l.want_ptr = 1'b0;
                            end else begin
                                nxt_l.req_tgl  = ~l_ff.req_tgl;
                                nxt_l.req_we   = 1'b1;
                                nxt_l.req_addr = l_ff.ptr;
                                nxt_l.req_data = l_ff.shreg;
                                nxt_l.ptr      = l_ff.ptr + ashc_pkg::PTR_STEP;
                            end
                        end
                    end
                end
                ashc_pkg::LK_ADDR_ACK: begin
                    if (lk_fall) begin
                        if (l_ff.rw) begin
                            nxt_l.shreg    = l_ff.rdata;
                            nxt_l.sda_oe_n = l_ff.rdata[7];
                            nxt_l.bits     = ashc_pkg::BIT_ONE;
                            nxt_l.st       = ashc_pkg::LK_RDATA;
                        end else begin
                            nxt_l.sda_oe_n = 1'b1;
                            nxt_l.st       = ashc_pkg::LK_WDATA;
                        end
                    end
                end
                ashc_pkg::LK_WACK: begin
                    if (lk_fall) begin
                        nxt_l.sda_oe_n = 1'b1;
                        nxt_l.st       = ashc_pkg::LK_WDATA;
                    end
                end
                ashc_pkg::LK_RDATA: begin
                    if (lk_fall) begin
                        if (l_ff.bits == ashc_pkg::BYTE_BITS) begin
                            nxt_l.sda_oe_n = 1'b1;
                            nxt_l.bits     = ashc_pkg::BITS_NONE;
                            nxt_l.st       = ashc_pkg::LK_RACK;
                            nxt_l.ptr      = l_ff.ptr + ashc_pkg::PTR_STEP;
                            // prefetch the next byte during the acknowledge bit
                            nxt_l.req_tgl  = ~l_ff.req_tgl;
                            nxt_l.req_we   = 1'b0;
                            nxt_l.req_addr = l_ff.ptr + ashc_pkg::PTR_STEP;
                        end else begin
                            nxt_l.shreg    = {l_ff.shreg[6:0], 1'b0};
                            nxt_l.sda_oe_n = l_ff.shreg[6];
                            nxt_l.bits     = l_ff.bits + ashc_pkg::BIT_STEP;
                        end
                    end
                end
                ashc_pkg::LK_RACK: begin
                    if (lk_rise) begin
                        if (lk_sda) nxt_l.st = ashc_pkg::LK_IDLE;
                        else nxt_l.bits = ashc_pkg::BIT_ONE;
                    end else if (lk_fall && l_ff.bits == ashc_pkg::BIT_ONE) begin
                        nxt_l.shreg    = l_ff.rdata;
                        nxt_l.sda_oe_n = l_ff.rdata[7];
                        nxt_l.st       = ashc_pkg::LK_RDATA;
                    end
                end
                default: nxt_l.st = ashc_pkg::LK_IDLE;
            endcase
        end
        if (!l_ff.rst_s[1]) begin
            nxt_l.st       = ashc_pkg::LK_IDLE;
            nxt_l.bits     = ashc_pkg::BITS_NONE;
            nxt_l.shreg    = ashc_pkg::BYTE_RESET;
            nxt_l.ptr      = ashc_pkg::PTR_RESET;
            nxt_l.rdata    = ashc_pkg::BYTE_RESET;
            nxt_l.rw       = 1'b0;
            nxt_l.want_ptr = 1'b0;
            nxt_l.sda_oe_n = 1'b1;
            nxt_l.req_tgl  = 1'b0;
            nxt_l.req_we   = 1'b0;
            nxt_l.req_addr = ashc_pkg::BYTE_RESET;
            nxt_l.req_data = ashc_pkg::BYTE_RESET;
        end
    end

    always_ff @(posedge link_clk) begin
        l_ff <= nxt_l;
    end

    assign sda_o    = 1'b0;
    assign sda_oe_n = l_ff.sda_oe_n;

    // ---------------- checks ----------------
    a_init_clears_regs: assert property (@(posedge core_clk) disable iff (!rstn)
        c_ff.pwr == ashc_pkg::PW_INIT |-> c_ff.paths_open ##1
        (c_ff.events == ashc_pkg::BYTE_RESET || c_ff.pwr == ashc_pkg::PW_STANDBY)
        && c_ff.control == ashc_pkg::BYTE_RESET)
        else $error("init did not clear registers or open paths");
    a_init_to_standby: assert property (@(posedge core_clk) disable iff (!rstn)
        (c_ff.pwr == ashc_pkg::PW_INIT && c_ff.bat_s[1] && !req_ev)
        |=> c_ff.pwr == ashc_pkg::PW_STANDBY && c_ff.standby)
        else $error("no standby after init");
    a_por_on_rise: assert property (@(posedge core_clk) disable iff (!rstn)
        (c_ff.pwr == ashc_pkg::PW_OFF && (c_ff.bat_s[1] || c_ff.bus_s[1]))
        |=> c_ff.pwr == ashc_pkg::PW_INIT)
        else $error("power-on reset missed");
    a_soft_reset_init: assert property (@(posedge core_clk) disable iff (!rstn)
        (req_ev && l_ff.req_we && l_ff.req_addr == ashc_pkg::REG_RESET_CTRL
         && l_ff.req_data[ashc_pkg::RST_BIT]) |=> c_ff.pwr == ashc_pkg::PW_INIT ##1 1'b1
        ##1 c_ff.control == ashc_pkg::BYTE_RESET)
        else $error("software reset did not initialise");
    a_detect_needs_bat: assert property (@(posedge core_clk) disable iff (!rstn)
        detect_enable |-> c_ff.bat_s[2] && standby)
        else $error("detection enabled without battery");
    a_bus_only_off: assert property (@(posedge core_clk) disable iff (!rstn)
        (c_ff.bus_s[2] && !c_ff.bat_s[2] && $stable(c_ff.bus_s[2]))
        |-> charge_enable && !detect_enable && !host_enable && !ldo_enable)
        else $error("bus-only state enabled other functions");
    a_all_off: assert property (@(posedge core_clk) disable iff (!rstn)
        (!c_ff.bat_s[2] && !c_ff.bus_s[2])
        |-> !charge_enable && !detect_enable && !ldo_enable
        && illegal_supply == c_ff.io_s[2])
        else $error("function on with no supply");
    a_int_gated: assert property (@(posedge core_clk) disable iff (!rstn)
        !host_enable |-> int_n)
        else $error("interrupt raised without io supply");
    a_int_on_change: assert property (@(posedge core_clk) disable iff (!rstn)
        (c_ff.pwr == ashc_pkg::PW_STANDBY && c_ff.bat_s[1] && c_ff.io_s[1] && !req_ev
         && !c_ff.control[ashc_pkg::CTL_INT_MASK] && went(c_ff.id_s[2], c_ff.id_s[1]))
        |=> !int_n)
        else $error("id change did not raise interrupt");
    a_link_gated: assert property (@(posedge link_clk) disable iff (!l_ff.rst_s[1])
        !lk_host |=> sda_oe_n && l_ff.st == ashc_pkg::LK_IDLE)
        else $error("link active without io supply");
    a_addr_ack: assert property (@(posedge link_clk) disable iff (!l_ff.rst_s[1])
        (l_ff.st == ashc_pkg::LK_ADDR && lk_host && lk_fall && !lk_start
         && l_ff.bits == ashc_pkg::BYTE_BITS && l_ff.shreg[7:1] == TARGET_ADDRESS)
        |=> !sda_oe_n && l_ff.st == ashc_pkg::LK_ADDR_ACK && l_ff.rw == $past(l_ff.shreg[0]))
        else $error("own address not acknowledged");
    a_ptr_advance: assert property (@(posedge link_clk) disable iff (!l_ff.rst_s[1])
        (l_ff.st == ashc_pkg::LK_WDATA && lk_host && lk_fall && !lk_init && !l_ff.want_ptr
         && l_ff.bits == ashc_pkg::BYTE_BITS)
        |=> l_ff.ptr == $past(l_ff.ptr) + ashc_pkg::PTR_STEP && !sda_oe_n)
        else $error("pointer did not advance after write byte");
    a_nack_release: assert property (@(posedge link_clk) disable iff (!l_ff.rst_s[1])
        (l_ff.st == ashc_pkg::LK_RACK && lk_host && lk_rise && lk_sda)
        |-> sda_oe_n ##1 (l_ff.st == ashc_pkg::LK_IDLE && sda_oe_n))
        else $error("data line held during master acknowledge");
endmodule // ashc_top

// >>> core/ashc_pkg.sv
// constants, field layout and state encodings of the accessory switch host control core
// assumes one core clock domain and one free-running link sampling clock at the i2c pins
// Function
// - any reset loads register defaults and opens every analog switch path
// - after reset or power-up, enter standby watching bus voltage and id input
// - power-on reset on first rising edge of battery or bus supply valid
// - writing the reset bit at offset 1b gives the same initialisation as hardware
// - detection and switching run whenever the battery supply is valid
// - i2c traffic and interrupts work only while the i/o supply is valid
// - charging only with valid bus supply; bus alone keeps everything else off; here bus alone still enters standby with switch_paths_open low
// - supplies may come up in any order
// - fast-mode i2c target, serial clock up to 400 khz
// - address byte carries seven-bit address in bits 7..1, bit 0 read high
// - read without register address starts at the current register pointer
// - active-low interrupt when the id input or attach state changes
package ashc_pkg;
    localparam logic [6:0] TARGET_ADDR    = 7'h25;
    localparam logic [3:0] RSV_ADDR_LO    = 4'h0;
    localparam logic [3:0] RSV_ADDR_HI    = 4'hf;
    localparam logic [7:0] REG_RESET_CTRL = 8'h1b;
    localparam logic [7:0] REG_STATUS     = 8'h1c;
    localparam logic [7:0] REG_EVENTS     = 8'h1d;
    localparam logic [7:0] REG_CONTROL    = 8'h1e;
    localparam int         RST_BIT        = 0;
    localparam int         STS_BAT        = 0;
    localparam int         STS_BUS        = 1;
    localparam int         STS_IO         = 2;
    localparam int         STS_ID         = 3;
    localparam int         STS_ATTACH     = 4;
    localparam int         STS_STANDBY    = 5;
    localparam int         EVT_ID         = 0;
    localparam int         EVT_ATTACH     = 1;
    localparam int         CTL_INT_MASK   = 0;
    localparam logic [7:0] BYTE_RESET     = 8'h00;
    localparam logic [7:0] PTR_RESET      = 8'h00;
    localparam logic [7:0] PTR_STEP       = 8'h01;
    localparam logic [3:0] BYTE_BITS      = 4'h8;
    localparam logic [3:0] BIT_STEP       = 4'h1;
    localparam logic [3:0] BITS_NONE      = 4'h0;
    localparam logic [3:0] BIT_ONE        = 4'h1;
    localparam int         SCL_MAX_KHZ    = 400;

    typedef enum logic [1:0] {
        PW_OFF     = 2'b00,
        PW_INIT    = 2'b01,
        PW_STANDBY = 2'b10
    } ashc_pwr_t;

    typedef enum logic [2:0] {
        LK_IDLE     = 3'b000,
        LK_ADDR     = 3'b001,
        LK_ADDR_ACK = 3'b010,
        LK_WDATA    = 3'b011,
        LK_WACK     = 3'b100,
        LK_RDATA    = 3'b101,
        LK_RACK     = 3'b110
    } ashc_link_t;

    // core domain state; the _s fields are pin and toggle synchronisers
    typedef struct packed {
        logic [2:0] bat_s;
        logic [2:0] bus_s;
        logic [2:0] io_s;
        logic [2:0] id_s;
        logic [2:0] att_s;
        logic [2:0] req_s;
        ashc_pwr_t  pwr;
        logic [7:0] control;
        logic [7:0] events;
        logic [7:0] rdata;
        logic       ack_tgl;
        logic       init_tgl;
        logic       int_n;
        logic       paths_open;
        logic       det_en;
        logic       chg_en;
        logic       ldo_en;
        logic       host_en;
        logic       illegal;
        logic       standby;
    } ashc_core_t;

    // link domain state
    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [1:0] rst_s;
        logic [1:0] host_s;
        logic [2:0] ack_s;
        logic [2:0] init_s;
        ashc_link_t st;
        logic [3:0] bits;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic [7:0] rdata;
        logic       rw;
        logic       want_ptr;
        logic       sda_oe_n;
        logic       req_tgl;
        logic       req_we;
        logic [7:0] req_addr;
        logic [7:0] req_data;
    } ashc_link_st_t;
endpackage

// >>> dv/ashc_master.sv
// i2c master model: open-drain data, serial clock still between frames
// assumes the bench resolves sda with a pull-up and returns it on sda_w
`timescale 1ns/1ps
module ashc_master (
    input  wire logic core_clk,
    input  wire logic sda_w,
    output logic      scl,
    output logic      sda_m
);
    initial {scl, sda_m} = 2'b11;
    task automatic wq(); repeat (63) @(posedge core_clk); endtask // quarter bit, 400 khz
    task automatic start();
        sda_m <= 1'b1; wq(); scl <= 1'b1; wq(); sda_m <= 1'b0; wq(); scl <= 1'b0; wq();
    endtask
    task automatic stop(); sda_m <= 1'b0; wq(); scl <= 1'b1; wq(); sda_m <= 1'b1; wq(); endtask
    task automatic bit_io(input logic b, output logic r);
        sda_m <= b; wq(); scl <= 1'b1; wq(); r = sda_w; wq(); scl <= 1'b0; wq();
    endtask
    // last high releases the line, also used as not_acknowledge
    task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
                           output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]); // msb first
        bit_io(last, ack);
    endtask
endmodule // ashc_master

// >>> dv/tb.sv
// self-checking bench: supply gating, reset and register access over i2c
// assumes ashc_master paces the serial clock from core_clk
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb;
    logic core_clk = 0, link_clk = 0, rstn = 0, bat_supply_valid = 0, bus_supply_input = 0;
    logic io_supply = 0, connector_id_pin = 0, attach_state = 0, sda_o, sda_oe_n, int_n;
    logic switch_paths_open, detect_enable, charge_enable, ldo_enable, host_enable;
    logic illegal_supply, standby, scl_i, sda_m, k;
    logic [7:0] ctl = 8'h00, ev = 8'h00, ptr = 8'h00, q;
    int errors = 0, samples_checked = 0, seed = 32'he2e7;
    wire sda_i = sda_m & (sda_oe_n | sda_o); // pulled-up wire
    initial forever #5 core_clk = ~core_clk;
    initial begin #3; forever #24 link_clk = ~link_clk; end
    ashc_top dut (.core_clk, .rstn, .link_clk, .scl_i, .sda_i, .sda_o, .sda_oe_n,
        .bat_supply_valid, .bus_supply_input, .io_supply, .connector_id_pin, .attach_state,
        .int_n, .switch_paths_open, .detect_enable, .charge_enable, .ldo_enable,
        .host_enable, .illegal_supply, .standby);
    ashc_master m (.core_clk, .sda_w(sda_i), .scl(scl_i), .sda_m);
    function automatic logic [7:0] ex(logic [7:0] p);
        return p == 8'h1e ? ctl : p == 8'h1d ? ev : p != 8'h1c ? 8'h00 : {3'b001, attach_state,
            connector_id_pin, io_supply, bus_supply_input, bat_supply_valid};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit dat);
        m.start();
        m.byte_io({ashc_pkg::TARGET_ADDR, 1'b0}, 1'b1, q, k);
        `CHK("ack", 1'b0, k)
        m.byte_io(a, 1'b1, q, k);
        ptr = a;
        if (dat) begin
            m.byte_io(d, 1'b1, q, k);
            `CHK("ack", 1'b0, k)
            ptr = a + 8'h01;
            if (a == 8'h1e) ctl = d;
            if (a == 8'h1b) begin ctl = 8'h00; ev = 8'h00; ptr = 8'h00; end
        end
        m.stop();
    endtask
    task automatic rd(input int n);
        m.start();
        m.byte_io({ashc_pkg::TARGET_ADDR, 1'b1}, 1'b1, q, k);
        for (int i = 0; i < n; i++) begin
            m.byte_io(8'hff, i == n - 1, q, k);
            `CHK("rdata", ex(ptr), q)
            if (ptr == 8'h1d) ev = 8'h00;
            ptr++;
        end
        m.stop();
    endtask
    task automatic tally_and_finish();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin repeat (100000) @(posedge core_clk); errors++; tally_and_finish(); end
    initial begin
        repeat (8) @(posedge core_clk);
        `CHK("open", 1'b1, switch_paths_open)
        rstn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            {bus_supply_input, bat_supply_valid, io_supply} <= 3'(i ^ 5);
            connector_id_pin <= 1'($random(seed));
            repeat (12) @(posedge core_clk);
            `CHK("sby", bus_supply_input | bat_supply_valid, standby)
            `CHK("det", bat_supply_valid, detect_enable)
            `CHK("ldo", bat_supply_valid, ldo_enable)
            `CHK("chg", bus_supply_input, charge_enable)
            `CHK("host", io_supply & bat_supply_valid, host_enable)
            `CHK("ill", io_supply & ~bat_supply_valid & ~bus_supply_input, illegal_supply)
        end
        {rstn, io_supply} <= 2'b01;
        repeat (8) @(posedge core_clk);
        `CHK("int", 1'b1, int_n)
        rstn <= 1'b1;
        repeat (12) @(posedge core_clk);
        wr(8'h1e, 8'h01, 1);
        wr(8'h1c, 8'h00, 0);
        rd(2);
        rd(1);
        connector_id_pin <= ~connector_id_pin;
        repeat (12) @(posedge core_clk);
        `CHK("masked", 1'b1, int_n)
        m.start();
        m.byte_io({ashc_pkg::TARGET_ADDR ^ 7'h01, 1'b0}, 1'b1, q, k);
        m.stop();
        `CHK("foreign", 1'b1, k)
        wr(8'h1b, 8'h01, 1);
        repeat (12) @(posedge core_clk);
        wr(8'h1e, 8'h00, 0);
        rd(2);
        attach_state <= ~attach_state;
        ev = 8'h02;
        repeat (12) @(posedge core_clk);
        `CHK("int", 1'b0, int_n)
        wr(8'h1d, 8'h00, 0);
        rd(1);
        `CHK("int", 1'b1, int_n)
        tally_and_finish();
    end
endmodule // tb
